// *** shared/osr_defs.svh ***
`ifndef OSR_DEFS_SVH
`define OSR_DEFS_SVH
// register byte addresses
`define OSR_ADDR_SELECT 12'h000
`define OSR_ADDR_ACTIVE 12'h004
`define OSR_ADDR_CTRL 12'h008
`define OSR_ADDR_STATUS 12'h00c
// field positions inside the selection word
`define OSR_POS_DONE 0
`define OSR_POS_MATCH 4
`define OSR_POS_ROT 8
`define OSR_POS_READY 12
`define OSR_FIELD_W 4
// reset values
`define OSR_SELECT_RST 16'h0000
// control bits
`define OSR_CTRL_RESTART 0
// field codes
`define OSR_CODE_OFF 4'h0
`define OSR_CODE_PAIR1 4'h1
`define OSR_CODE_PAIR2 4'h2
`define OSR_CODE_RSV_LO 4'h3
`define OSR_CODE_RSV_HI 4'h6
`endif

// *** shared/osr_pkg.sv ***
package osr_pkg;
   typedef enum logic [1:0] {
      OSR_ROUTE_OFF = 2'b00,
      OSR_ROUTE_PAIR1 = 2'b01,
      OSR_ROUTE_PAIR2 = 2'b10,
      OSR_ROUTE_RSV = 2'b11
   } osr_route_t;
endpackage

// *** hdl/osr_field_route.sv ***
`timescale 1ns/100ps
`include "osr_defs.svh"
// routes one status signal of both axes onto the selected terminal pair
module osr_field_route
   import osr_pkg::*;
(
   input wire logic [3:0] fieldCode,
   input wire logic statusA,
   input wire logic statusB,
   output osr_pkg::osr_route_t route,
   output logic [1:0] pairA,
   output logic [1:0] pairB
);
   import osr_pkg::*;

   // decode of the field value, reserved codes drive nothing
   function automatic osr_route_t decode(input logic [3:0] code);
      if (code == `OSR_CODE_OFF)
         decode = OSR_ROUTE_OFF;
      else if (code == `OSR_CODE_PAIR1)
         decode = OSR_ROUTE_PAIR1;
      else if (code == `OSR_CODE_PAIR2)
         decode = OSR_ROUTE_PAIR2;
      else
         decode = OSR_ROUTE_RSV;
   endfunction

   // bit 0 is the first pair, bit 1 the alternate pair
   assign route = decode(fieldCode);
   assign pairA = {route == OSR_ROUTE_PAIR2 && statusA, route == OSR_ROUTE_PAIR1 && statusA};
   assign pairB = {route == OSR_ROUTE_PAIR2 && statusB, route == OSR_ROUTE_PAIR1 && statusB};
endmodule

// *** hdl/osr_output_routing.sv ***
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/100ps
`include "osr_defs.svh"
// Contract
// - done field zero drives no terminal; codes three to six are reserved, drive nothing.
// - code one uses first pairs per axis, code two the alternate pairs.
// - match, rotation and ready fields decode exactly like the done field.
// - done routing is bits 3:0, speed match routing bits 7:4.
// - ready routing is bits 15:12, rotation routing bits 11:8.
module osr_output_routing
   import osr_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [1:0] positioningDone,
   input wire logic [1:0] speedMatch,
   input wire logic [1:0] rotationDetect,
   input wire logic [1:0] readyToRun,
   output logic [3:0] positioning_done_out,
   output logic [3:0] speed_match_out,
   output logic [3:0] rotation_detect_out,
   output logic [3:0] ready_out,
   output logic cfgReserved
);
   import osr_pkg::*;

   logic rstSync1_reg;
   logic rstSync2_reg;
   logic rstN;
   logic [15:0] select_reg;
   logic [15:0] active_reg;
   logic restart_reg;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic [3:0] doneOut_reg;
   logic [3:0] matchOut_reg;
   logic [3:0] rotOut_reg;
   logic [3:0] readyOut_reg;
   logic cfgReserved_reg;

   // reset release through two flip-flops
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rstSync1_reg <= 1'b0;
         rstSync2_reg <= 1'b0;
      end
      else
      begin
         rstSync1_reg <= 1'b1;
         rstSync2_reg <= rstSync1_reg;
      end
   end
   assign rstN = rstSync2_reg;

   // bus decode
   wire setup = psel && !penable;
   wire access = psel && penable;
   wire hitSelect = paddr == `OSR_ADDR_SELECT;
   wire hitActive = paddr == `OSR_ADDR_ACTIVE;
   wire hitCtrl = paddr == `OSR_ADDR_CTRL;
   wire hitStatus = paddr == `OSR_ADDR_STATUS;
   wire mapped = hitSelect || hitActive || hitCtrl || hitStatus;
   wire wrSelect = access && pwrite && hitSelect && pready_reg;
   wire wrRestart = access && pwrite && hitCtrl && pready_reg && pwdata[`OSR_CTRL_RESTART];

   // routes decoded from the active (latched) word
   osr_route_t routeDone;
   osr_route_t routeMatch;
   osr_route_t routeRot;
   osr_route_t routeReady;
   logic [1:0] doneA;
   logic [1:0] doneB;
   logic [1:0] matchA;
   logic [1:0] matchB;
   logic [1:0] rotA;
   logic [1:0] rotB;
   logic [1:0] readyA;
   logic [1:0] readyB;

   // field slicing of the active word
   osr_field_route uDone (
      .fieldCode(active_reg[`OSR_POS_DONE +: `OSR_FIELD_W]),
      .statusA(positioningDone[0]),
      .statusB(positioningDone[1]),
      .route(routeDone),
      .pairA(doneA),
      .pairB(doneB)
   );
   osr_field_route uMatch (
      .fieldCode(active_reg[`OSR_POS_MATCH +: `OSR_FIELD_W]),
      .statusA(speedMatch[0]),
      .statusB(speedMatch[1]),
      .route(routeMatch),
      .pairA(matchA),
      .pairB(matchB)
   );
   osr_field_route uRot (
      .fieldCode(active_reg[`OSR_POS_ROT +: `OSR_FIELD_W]),
      .statusA(rotationDetect[0]),
      .statusB(rotationDetect[1]),
      .route(routeRot),
      .pairA(rotA),
      .pairB(rotB)
   );
   osr_field_route uReady (
      .fieldCode(active_reg[`OSR_POS_READY +: `OSR_FIELD_W]),
      .statusA(readyToRun[0]),
      .statusB(readyToRun[1]),
      .route(routeReady),
      .pairA(readyA),
      .pairB(readyB)
   );

   // terminal order: {axisB alt, axisA alt, axisB first, axisA first}
   wire [3:0] doneNext = {doneB[1], doneA[1], doneB[0], doneA[0]};
   wire [3:0] matchNext = {matchB[1], matchA[1], matchB[0], matchA[0]};
   wire [3:0] rotNext = {rotB[1], rotA[1], rotB[0], rotA[0]};
   wire [3:0] readyNext = {readyB[1], readyA[1], readyB[0], readyA[0]};
   wire reservedNext = (routeDone == OSR_ROUTE_RSV) || (routeMatch == OSR_ROUTE_RSV)
      || (routeRot == OSR_ROUTE_RSV) || (routeReady == OSR_ROUTE_RSV);

   // read mux
   wire [31:0] rdNext = hitSelect ? {16'h0000, select_reg} :
      hitActive ? {16'h0000, active_reg} :
      hitStatus ? {31'h00000000, cfgReserved_reg} : 32'h00000000;

   // stored selection word
   always_ff @(posedge mclk or negedge rstN)
   begin
      if (!rstN)
         select_reg <= `OSR_SELECT_RST;
      else if (wrSelect)
         select_reg <= pwdata[15:0];
   end

   // active word copied only on restart and in the first cycle after reset release
   always_ff @(posedge mclk or negedge rstN)
   begin
      if (!rstN)
         restart_reg <= 1'b1;
      else
         restart_reg <= wrRestart;
   end
   always_ff @(posedge mclk or negedge rstN)
   begin
      if (!rstN)
         active_reg <= `OSR_SELECT_RST;
      else if (restart_reg)
         active_reg <= select_reg;
   end

   // bus answer, no wait state
   always_ff @(posedge mclk or negedge rstN)
   begin
      if (!rstN)
      begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h00000000;
      end
      else
      begin
         pready_reg <= setup;
         pslverr_reg <= setup && !mapped;
         prdata_reg <= (setup && !pwrite) ? rdNext : 32'h00000000;
      end
   end

   // registered terminal outputs
   always_ff @(posedge mclk or negedge rstN)
   begin
      if (!rstN)
      begin
         doneOut_reg <= 4'h0;
         matchOut_reg <= 4'h0;
         rotOut_reg <= 4'h0;
         readyOut_reg <= 4'h0;
         cfgReserved_reg <= 1'b0;
      end
      else
      begin
         doneOut_reg <= doneNext;
         matchOut_reg <= matchNext;
         rotOut_reg <= rotNext;
         readyOut_reg <= readyNext;
         cfgReserved_reg <= reservedNext;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign positioning_done_out = doneOut_reg;
   assign speed_match_out = matchOut_reg;
   assign rotation_detect_out = rotOut_reg;
   assign ready_out = readyOut_reg;
   assign cfgReserved = cfgReserved_reg;

   // assertions
   sequence restartReq;
      wrRestart;
   endsequence
   sequence activeTaken;
      ##2 active_reg == $past(select_reg, 1);
   endsequence

   restart_latch_a: assert property (@(posedge mclk) disable iff (!rstN)
      restartReq |-> activeTaken)
      else $error("active word not taken on restart");
   hold_active_a: assert property (@(posedge mclk) disable iff (!rstN)
      !restart_reg |=> $stable(active_reg))
      else $error("active word changed without restart");
   done_off_a: assert property (@(posedge mclk) disable iff (!rstN)
      active_reg[3:0] == 4'h0 |=> positioning_done_out == 4'h0)
      else $error("done driven while disabled");
   done_pair1_a: assert property (@(posedge mclk) disable iff (!rstN)
      active_reg[3:0] == 4'h1 |=> positioning_done_out == {2'b00, $past(positioningDone)})
      else $error("done first pair wrong");
   match_pair2_a: assert property (@(posedge mclk) disable iff (!rstN)
      active_reg[7:4] == 4'h2 |=> speed_match_out == {$past(speedMatch), 2'b00})
      else $error("match alternate pair wrong");
   rot_field_a: assert property (@(posedge mclk) disable iff (!rstN)
      active_reg[11:8] == 4'h1 |=> rotation_detect_out == {2'b00, $past(rotationDetect)})
      else $error("rotation routing wrong");
   ready_reserved_a: assert property (@(posedge mclk) disable iff (!rstN)
      active_reg[15:12] >= 4'h3 |=> ready_out == 4'h0 && cfgReserved)
      else $error("reserved ready code drove output");
   match_field_a: assert property (@(posedge mclk) disable iff (!rstN)
      active_reg[7:4] == 4'h0 |=> speed_match_out == 4'h0)
      else $error("match field position wrong");

   // bus answer checks
   sequence setupPhase;
      psel && !penable;
   endsequence
   sequence readyPulse;
      pready ##1 !pready;
   endsequence

   ready_answer_a: assert property (@(posedge mclk) disable iff (!rstN)
      setupPhase |=> readyPulse)
      else $error("ready not a one cycle answer to setup");
   ready_alone_a: assert property (@(posedge mclk) disable iff (!rstN)
      pready |-> $past(psel) && !$past(penable))
      else $error("ready without a setup cycle");
   error_unmapped_a: assert property (@(posedge mclk) disable iff (!rstN)
      psel && !penable && !mapped |=> pslverr && pready)
      else $error("unmapped address not flagged");
   error_mapped_a: assert property (@(posedge mclk) disable iff (!rstN)
      psel && !penable && mapped |=> !pslverr)
      else $error("mapped address flagged");
   error_ready_a: assert property (@(posedge mclk) disable iff (!rstN)
      pslverr |-> pready)
      else $error("error without ready");
   read_idle_a: assert property (@(posedge mclk) disable iff (!rstN)
      !pready |-> prdata == 32'h00000000)
      else $error("read data outside answer cycle");

   // register contents
   select_write_a: assert property (@(posedge mclk) disable iff (!rstN)
      wrSelect |=> select_reg == $past(pwdata[15:0]))
      else $error("selection word write lost");
   select_read_a: assert property (@(posedge mclk) disable iff (!rstN)
      psel && !penable && !pwrite && hitSelect
      |=> prdata == {16'h0000, $past(select_reg)})
      else $error("selection word read wrong");
   status_read_a: assert property (@(posedge mclk) disable iff (!rstN)
      psel && !penable && !pwrite && hitStatus
      |=> prdata == {31'h00000000, $past(cfgReserved)})
      else $error("status read wrong");

   // routing of the remaining codes
   done_pair2_a: assert property (@(posedge mclk) disable iff (!rstN)
      active_reg[3:0] == 4'h2 |=> positioning_done_out == {$past(positioningDone), 2'b00})
      else $error("done alternate pair wrong");
   done_reserved_a: assert property (@(posedge mclk) disable iff (!rstN)
      active_reg[3:0] >= 4'h3 |=> positioning_done_out == 4'h0 && cfgReserved)
      else $error("reserved done code drove output");
   match_pair1_a: assert property (@(posedge mclk) disable iff (!rstN)
      active_reg[7:4] == 4'h1 |=> speed_match_out == {2'b00, $past(speedMatch)})
      else $error("match first pair wrong");
   rot_alt_a: assert property (@(posedge mclk) disable iff (!rstN)
      active_reg[11:8] == 4'h2 |=> rotation_detect_out == {$past(rotationDetect), 2'b00})
      else $error("rotation alternate pair wrong");
   rot_off_a: assert property (@(posedge mclk) disable iff (!rstN)
      active_reg[11:8] == 4'h0 |=> rotation_detect_out == 4'h0)
      else $error("rotation driven while disabled");
   ready_pair1_a: assert property (@(posedge mclk) disable iff (!rstN)
      active_reg[15:12] == 4'h1 |=> ready_out == {2'b00, $past(readyToRun)})
      else $error("ready first pair wrong");
   ready_alt_a: assert property (@(posedge mclk) disable iff (!rstN)
      active_reg[15:12] == 4'h2 |=> ready_out == {$past(readyToRun), 2'b00})
      else $error("ready alternate pair wrong");
   ready_off_a: assert property (@(posedge mclk) disable iff (!rstN)
      active_reg[15:12] == 4'h0 |=> ready_out == 4'h0)
      else $error("ready driven while disabled");
   clean_config_a: assert property (@(posedge mclk) disable iff (!rstN)
      active_reg[3:0] < 4'h3 && active_reg[7:4] < 4'h3
      && active_reg[11:8] < 4'h3 && active_reg[15:12] < 4'h3 |=> !cfgReserved)
      else $error("reserved flag without a reserved code");
endmodule

// *** dv/osr_terminal_reader.sv ***
`timescale 1ns/100ps
// external controller that latches the four terminal groups every clock
module osr_terminal_reader
(
   input wire logic mclk,
   input wire logic [3:0] doneTerm,
   input wire logic [3:0] matchTerm,
   input wire logic [3:0] rotTerm,
   input wire logic [3:0] readyTerm,
   output logic [15:0] seen
);
   // input stage of the controller, one register deep
   always_ff @(posedge mclk)
   begin
      seen <= {readyTerm, rotTerm, matchTerm, doneTerm};
   end
endmodule

// *** dv/osr_output_routing_tb.sv ***
`timescale 1ns/100ps
`include "osr_defs.svh"
module osr_output_routing_tb;
   import osr_pkg::*;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [1:0] pd = 2'h0;
   logic [1:0] sm = 2'h0;
   logic [1:0] rt = 2'h0;
   logic [1:0] rr = 2'h0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic pready;
   logic pslverr;
   logic err;
   logic cfgReserved;
   logic [3:0] o0;
   logic [3:0] o1;
   logic [3:0] o2;
   logic [3:0] o3;
   logic [15:0] seen;
   logic [15:0] act;
   int fails = 0;
   int compares = 0;
   // 4 ns clock
   always #2 mclk = ~mclk;
   osr_output_routing dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .positioningDone(pd), .speedMatch(sm), .rotationDetect(rt),
      .readyToRun(rr), .positioning_done_out(o0), .speed_match_out(o1),
      .rotation_detect_out(o2), .ready_out(o3), .cfgReserved(cfgReserved));
   osr_terminal_reader host (.mclk(mclk), .doneTerm(o0), .matchTerm(o1), .rotTerm(o2),
      .readyTerm(o3), .seen(seen));
   // expected terminal group for one field code
   function automatic logic [3:0] route(input logic [3:0] c, input logic [1:0] s);
      return (c == `OSR_CODE_PAIR1) ? {2'b00, s} : (c == `OSR_CODE_PAIR2) ? {s, 2'b00} : 4'h0;
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         fails++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one apb transfer, entered just after a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do
         @(posedge mclk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   // program a word, restart, then route random status through it
   task automatic word(input logic [15:0] w);
      logic rsv;
      rsv = 1'b0;
      for (int f = 0; f < 4; f++)
         rsv = rsv | (w[f*4 +: 4] > `OSR_CODE_PAIR2);
      apb(1'b1, `OSR_ADDR_SELECT, {16'h0, w});
      apb(1'b0, `OSR_ADDR_ACTIVE, 32'h0);
      chk("active before restart", {16'h0, act}, rd);
      apb(1'b1, `OSR_ADDR_CTRL, 32'h1);
      act = w;
      repeat (3) @(posedge mclk);
      apb(1'b0, `OSR_ADDR_ACTIVE, 32'h0);
      chk("active after restart", {16'h0, w}, rd);
      apb(1'b0, `OSR_ADDR_STATUS, 32'h0);
      chk("status", {31'h0, rsv}, rd);
      repeat (4)
      begin
         pd <= 2'($urandom);
         sm <= 2'($urandom);
         rt <= 2'($urandom);
         rr <= 2'($urandom);
         repeat (3) @(posedge mclk);
         chk("terminals", {16'h0, route(w[15:12], rr), route(w[11:8], rt),
            route(w[7:4], sm), route(w[3:0], pd)}, {16'h0, seen});
         chk("cfgReserved", {31'h0, rsv}, {31'h0, cfgReserved});
      end
      $display("word %h done", w);
   endtask
   task automatic print_verdict();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // main sequence
   initial
   begin
      void'($urandom(63));
      act = `OSR_SELECT_RST;
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      apb(1'b0, `OSR_ADDR_SELECT, 32'h0);
      chk("select reset", 32'h0, rd);
      chk("terminals reset", 32'h0, {16'h0, o3, o2, o1, o0});
      for (int c = 0; c < 7; c++)
         word({4{4'(c)}});
      word(16'h0012);
      word(16'h2100);
      word(16'h9f07);
      repeat (10)
         word({4'($urandom_range(0, 6)), 4'($urandom_range(0, 6)),
            4'($urandom_range(0, 6)), 4'($urandom_range(0, 6))});
      apb(1'b0, 12'h010, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, rd);
      apb(1'b1, `OSR_ADDR_ACTIVE, 32'hffff);
      apb(1'b0, `OSR_ADDR_ACTIVE, 32'h0);
      chk("active read only", {16'h0, act}, rd);
      $display("bus checks done");
      print_verdict();
   end
   // hang guard
   initial
   begin
      #200000;
      fails++;
      print_verdict();
   end
endmodule
